/* File: src/pmc_ctrl.sv */
// How it works
// - Reset starts RUN at master clock rate.
// - Slow mode divides by 2/4/8/16.
// - Wait in slow keeps divided clock.
// - Wait stops CPU clock, peripherals run.
// - Wait entry forces mask bits to 10.
// - Wait ends on interrupt or reset.
// - CPU stacks mask; restore on pop.
// - Halt picks active-halt when timebase enabled.
// - Active-halt runs only oscillator and timebase.
// - Active-halt exit only timebase, no delay.
// - Active-halt reset exit uses stabilization delay.
// - Halt entry forces mask; pending wakes.
// - Active-halt with timebase: no watchdog reset.
// - Timebase cleared during delay: halt remainder.
// - Halt stops oscillator and all peripherals.
// - Halt exit restarts oscillator, waits delay.
// - Only chosen interrupts wake from halt.
// - Watchdog option: halt or watchdog reset.
// - Opcode 8E decodes as halt.
// - Serial interface wakes only in slave.
// - PWM timer wakes only on external clock.
module pmc_ctrl #(
    parameter int DELAY_SHORT = pmc_pkg::PMC_DELAY_SHORT,
    parameter int DELAY_LONG  = pmc_pkg::PMC_DELAY_LONG
) (
    // Clock and reset
    input  wire logic                 MCLK_IN,
    input  wire logic                 RST_N_IN,
    // Avalon-MM slave
    input  wire logic [3:0]           AVS_ADDRESS_IN,
    input  wire logic                 AVS_READ_IN,
    input  wire logic                 AVS_WRITE_IN,
    input  wire logic [31:0]          AVS_WRITEDATA_IN,
    output logic      [31:0]          AVS_READDATA_OUT,
    output logic                      AVS_WAITREQUEST_OUT,
    // CPU core
    input  wire pmc_pkg::pmc_cpu_req_t CPU_REQ_IN,
    input  wire logic                 WDG_ACTIVE_IN,
    // Interrupt sources, same clock domain
    input  wire pmc_pkg::pmc_irq_t    IRQ_IN,
    // Clock gates and control outputs
    output logic                      CPU_CLK_EN_OUT,
    output logic                      PERIPH_CLK_EN_OUT,
    output logic                      OSC_EN_OUT,
    output logic                      TIMEBASE_EN_OUT,
    output logic                      MASK_FORCE_OUT,
    output logic [1:0]                MASK_LEVEL_OUT,
    output logic                      WAKE_SERVICE_OUT,
    output logic                      WDG_RESET_OUT,
    output logic [4:0]                CLK_DIV_OUT
);
    import pmc_pkg::*;

    // ******************************************************************
    // Registers
    // ******************************************************************
    logic        slow_mode_enable_q;
    logic [1:0]  slow_divider_select_q;
    logic        timebase_interrupt_enable_q;
    logic        delay_long_q;
    logic        watchdog_halt_option_q;
    logic [1:0]  wake_cfg_q;
    logic [7:0]  last_opcode_q;
    pmc_state_t  state_q;
    logic [12:0] stab_cnt_q;
    logic        tb_wake_q;
    logic [12:0] tb_win_q;
    logic        was_reset_q;

    logic is_halt;
    logic halt_wake;
    logic [12:0] delay_cycles;

    // Opcode 8E is the halt instruction.
    // halt decode
    assign is_halt = CPU_REQ_IN.exec && (CPU_REQ_IN.opcode == PMC_HALT_OPCODE);

    // Only whitelisted sources leave halt; all others are ignored.
    // halt wake filter
    assign halt_wake = IRQ_IN.ext_irq
        || (IRQ_IN.spi_irq && wake_cfg_q[PMC_WK_SPI_SLAVE])
        || (IRQ_IN.art_irq && wake_cfg_q[PMC_WK_ART_EXT]);

    assign delay_cycles = delay_long_q ? 13'(DELAY_LONG) : 13'(DELAY_SHORT);

    // ******************************************************************
    // Bus slave
    // ******************************************************************
    // Waitrequest idles high and drops for one cycle once a request is
    // seen, so every transfer ends on its second edge.  One wait state is
    // traded for an output that comes straight from a flip-flop.
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            AVS_WAITREQUEST_OUT <= 1'b1;
        end else begin
            AVS_WAITREQUEST_OUT <= !((AVS_READ_IN || AVS_WRITE_IN) &&
                AVS_WAITREQUEST_OUT);
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            AVS_READDATA_OUT <= PMC_UNMAPPED_DATA;
        end else if (AVS_READ_IN && AVS_WAITREQUEST_OUT) begin
            case (AVS_ADDRESS_IN)
                PMC_ADDR_CTRL: begin
                    AVS_READDATA_OUT <= {26'h0, watchdog_halt_option_q,
                        delay_long_q, timebase_interrupt_enable_q,
                        slow_divider_select_q, slow_mode_enable_q};
                end
                PMC_ADDR_STATUS: begin
                    AVS_READDATA_OUT <= {26'h0, state_q};
                end
                PMC_ADDR_WAKE: begin
                    AVS_READDATA_OUT <= {30'h0, wake_cfg_q};
                end
                PMC_ADDR_OPCODE: begin
                    AVS_READDATA_OUT <= {24'h0, last_opcode_q};
                end
                default: begin
                    AVS_READDATA_OUT <= PMC_UNMAPPED_DATA;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            slow_mode_enable_q          <= PMC_CTRL_RESET[PMC_CTRL_SLOW_BIT];
            slow_divider_select_q       <= 2'b00;
            timebase_interrupt_enable_q <= PMC_CTRL_RESET[PMC_CTRL_TBIE_BIT];
            delay_long_q                <= PMC_CTRL_RESET[PMC_CTRL_LONG_BIT];
            watchdog_halt_option_q      <= PMC_CTRL_RESET[PMC_CTRL_WDGH_BIT];
            wake_cfg_q                  <= 2'b00;
        end else if (AVS_WRITE_IN && !AVS_WAITREQUEST_OUT) begin
            if (AVS_ADDRESS_IN == PMC_ADDR_CTRL) begin
                slow_mode_enable_q <= AVS_WRITEDATA_IN[PMC_CTRL_SLOW_BIT];
                slow_divider_select_q <=
                    AVS_WRITEDATA_IN[PMC_CTRL_DIV_LSB +: 2];
                timebase_interrupt_enable_q <=
                    AVS_WRITEDATA_IN[PMC_CTRL_TBIE_BIT];
                delay_long_q <= AVS_WRITEDATA_IN[PMC_CTRL_LONG_BIT];
                watchdog_halt_option_q <= AVS_WRITEDATA_IN[PMC_CTRL_WDGH_BIT];
            end
            if (AVS_ADDRESS_IN == PMC_ADDR_WAKE) begin
                wake_cfg_q <= AVS_WRITEDATA_IN[1:0];
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            last_opcode_q <= 8'h00;
        end else if (CPU_REQ_IN.exec) begin
            last_opcode_q <= CPU_REQ_IN.opcode;
        end
    end

    // ******************************************************************
    // Mode sequencer
    // ******************************************************************
    // Reset itself is counted as a wake from any mode; the power-on path
    // goes through the stabilization delay like a halt reset exit.
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            state_q     <= PMC_ST_STAB;
            stab_cnt_q  <= 13'h0000;
            was_reset_q <= 1'b1;
        end else begin
            case (state_q)
                PMC_ST_RUN: begin
                    was_reset_q <= 1'b0;
                    if (CPU_REQ_IN.wait_for_interrupt_instruction) begin
                        state_q <= PMC_ST_WAIT;
                    end else if (is_halt) begin
                        if (timebase_interrupt_enable_q) begin
                            state_q <= PMC_ST_AHALT;
                        end else if (!(WDG_ACTIVE_IN &&
                                       !watchdog_halt_option_q)) begin
                            state_q <= PMC_ST_HALT;
                        end
                    end
                end
                PMC_ST_WAIT: begin
                    if (IRQ_IN.any_irq) begin
                        state_q <= PMC_ST_RESUME;
                    end
                end
                PMC_ST_AHALT: begin
                    if (IRQ_IN.tb_irq) begin
                        state_q <= PMC_ST_RESUME;
                    end
                end
                PMC_ST_HALT: begin
                    if (halt_wake) begin
                        state_q    <= PMC_ST_STAB;
                        stab_cnt_q <= 13'h0000;
                    end
                end
                PMC_ST_STAB: begin
                    if (stab_cnt_q >= delay_cycles - 13'd1) begin
                        state_q <= was_reset_q ? PMC_ST_RUN : PMC_ST_RESUME;
                    end else begin
                        stab_cnt_q <= stab_cnt_q + 13'd1;
                    end
                end
                PMC_ST_RESUME: begin
                    state_q <= PMC_ST_RUN;
                end
                default: begin
                    state_q <= PMC_ST_RUN;
                end
            endcase
            if (state_q == PMC_ST_RUN && tb_wake_q &&
                !timebase_interrupt_enable_q) begin
                state_q <= PMC_ST_HALT;
            end
        end
    end

    // Window after an active-halt wake in which the timebase enable must
    // stay set.
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            tb_wake_q <= 1'b0;
            tb_win_q  <= 13'h0000;
        end else if (state_q == PMC_ST_AHALT && IRQ_IN.tb_irq) begin
            tb_wake_q <= 1'b1;
            tb_win_q  <= delay_cycles;
        end else if (tb_wake_q) begin
            tb_win_q <= tb_win_q - 13'd1;
            if (tb_win_q <= 13'd1 || state_q == PMC_ST_HALT) begin
                tb_wake_q <= 1'b0;
            end
        end
    end

    // ******************************************************************
    // Output flops
    // ******************************************************************
    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            CPU_CLK_EN_OUT    <= 1'b0;
            PERIPH_CLK_EN_OUT <= 1'b0;
            OSC_EN_OUT        <= 1'b1;
            TIMEBASE_EN_OUT   <= 1'b0;
            MASK_FORCE_OUT    <= 1'b0;
            MASK_LEVEL_OUT    <= PMC_MASK_ALL_ON;
            WAKE_SERVICE_OUT  <= 1'b0;
            WDG_RESET_OUT     <= 1'b0;
            CLK_DIV_OUT       <= 5'd1;
        end else begin
            CLK_DIV_OUT <= slow_mode_enable_q ?
                (5'd2 << slow_divider_select_q) : 5'd1;
            CPU_CLK_EN_OUT <= (state_q == PMC_ST_RUN) ||
                (state_q == PMC_ST_RESUME);
            PERIPH_CLK_EN_OUT <= (state_q == PMC_ST_RUN) ||
                (state_q == PMC_ST_WAIT) || (state_q == PMC_ST_RESUME);
            OSC_EN_OUT <= (state_q != PMC_ST_HALT);
            TIMEBASE_EN_OUT <= (state_q != PMC_ST_HALT) &&
                (state_q != PMC_ST_STAB);
            MASK_FORCE_OUT <= (state_q == PMC_ST_WAIT) ||
                (state_q == PMC_ST_AHALT) || (state_q == PMC_ST_HALT);
            MASK_LEVEL_OUT <= PMC_MASK_ALL_ON;
            WAKE_SERVICE_OUT <= (state_q == PMC_ST_RESUME);
            WDG_RESET_OUT <= (state_q == PMC_ST_RUN) && is_halt &&
                !timebase_interrupt_enable_q && WDG_ACTIVE_IN &&
                !watchdog_halt_option_q;
        end
    end

    // ******************************************************************
    // Checks
    // ******************************************************************
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);

    AST_WAIT_CPU_OFF: assert property (
        state_q == PMC_ST_WAIT |=> !CPU_CLK_EN_OUT && PERIPH_CLK_EN_OUT)
        else $error("cpu clock not stopped in wait");
    AST_WAIT_MASK: assert property (
        state_q == PMC_ST_WAIT |=> MASK_FORCE_OUT && MASK_LEVEL_OUT == 2'b10)
        else $error("mask not forced in wait");
    AST_WAIT_WAKE: assert property (
        state_q == PMC_ST_WAIT && IRQ_IN.any_irq |=> state_q == PMC_ST_RESUME)
        else $error("wait did not wake");
    AST_HALT_SEL: assert property (
        state_q == PMC_ST_RUN && is_halt && !CPU_REQ_IN.wait_for_interrupt_instruction &&
        timebase_interrupt_enable_q |=> state_q == PMC_ST_AHALT)
        else $error("active-halt not chosen");
    AST_AHALT_FAST: assert property (
        state_q == PMC_ST_AHALT && IRQ_IN.tb_irq
        |=> state_q == PMC_ST_RESUME ##1 state_q == PMC_ST_RUN)
        else $error("active-halt exit delayed");
    AST_HALT_OSC: assert property (
        state_q == PMC_ST_HALT |=> !OSC_EN_OUT && !PERIPH_CLK_EN_OUT)
        else $error("oscillator not off in halt");
    AST_HALT_IGNORE: assert property (
        state_q == PMC_ST_HALT && !halt_wake && !tb_wake_q
        |=> state_q == PMC_ST_HALT)
        else $error("halt left without allowed source");
    AST_DIV: assert property (
        slow_mode_enable_q && slow_divider_select_q == 2'b11
        && $stable(slow_mode_enable_q) |=> CLK_DIV_OUT == 5'd16)
        else $error("slow divider wrong");
    AST_OPCODE: assert property (
        state_q == PMC_ST_RUN && CPU_REQ_IN.exec && !CPU_REQ_IN.wait_for_interrupt_instruction &&
        CPU_REQ_IN.opcode == 8'h8E
        |=> state_q != PMC_ST_RUN || WDG_RESET_OUT)
        else $error("halt opcode not acted on");
    AST_STAB_OSC: assert property (
        state_q == PMC_ST_HALT && halt_wake
        |=> state_q == PMC_ST_STAB ##1 OSC_EN_OUT && !CPU_CLK_EN_OUT)
        else $error("halt exit not stabilizing");
    AST_RESET_START: assert property (
        $rose(RST_N_IN) |-> state_q == PMC_ST_STAB)
        else $error("reset exit skipped the delay");
    AST_RESUME_RUN: assert property (
        state_q == PMC_ST_RESUME |=> state_q == PMC_ST_RUN && WAKE_SERVICE_OUT)
        else $error("resume did not return to run");
    AST_AHALT_NO_WDG: assert property (
        state_q == PMC_ST_RUN && is_halt && timebase_interrupt_enable_q
        |=> !WDG_RESET_OUT)
        else $error("watchdog reset on active-halt entry");
    AST_TB_WINDOW: assert property (
        state_q == PMC_ST_RUN && tb_wake_q && !timebase_interrupt_enable_q
        |=> state_q == PMC_ST_HALT)
        else $error("timebase clear in window did not halt");
    AST_SLOW_WAIT_DIV: assert property (
        state_q == PMC_ST_WAIT && slow_mode_enable_q |=> CLK_DIV_OUT != 5'd1)
        else $error("slow-wait lost the divided clock");
    AST_AHALT_CLOCKS: assert property (
        state_q == PMC_ST_AHALT |=> OSC_EN_OUT && TIMEBASE_EN_OUT &&
        !PERIPH_CLK_EN_OUT && !CPU_CLK_EN_OUT)
        else $error("active-halt clocks wrong");
    AST_HALT_MASK: assert property (
        state_q == PMC_ST_AHALT || state_q == PMC_ST_HALT
        |=> MASK_FORCE_OUT && MASK_LEVEL_OUT == PMC_MASK_ALL_ON)
        else $error("mask not forced in halt");
    AST_WDG_PULSE: assert property (
        state_q == PMC_ST_RUN && is_halt && !timebase_interrupt_enable_q &&
        WDG_ACTIVE_IN && !watchdog_halt_option_q
        |=> WDG_RESET_OUT)
        else $error("watchdog reset missing on halt");
    AST_AHALT_STAY: assert property (
        state_q == PMC_ST_AHALT && !IRQ_IN.tb_irq |=> state_q == PMC_ST_AHALT)
        else $error("active-halt left without timebase");

    COV_WAIT: cover property (state_q == PMC_ST_WAIT ##1
        state_q == PMC_ST_RESUME);
    COV_AHALT: cover property (state_q == PMC_ST_AHALT ##1
        state_q == PMC_ST_RESUME);
    COV_HALT: cover property (state_q == PMC_ST_HALT ##1
        state_q == PMC_ST_STAB);
    COV_WDG: cover property (WDG_RESET_OUT);
    COV_TBWIN: cover property (state_q == PMC_ST_RUN && tb_wake_q ##1
        state_q == PMC_ST_HALT);

endmodule : pmc_ctrl

/* File: src/pmc_pkg.sv */
package pmc_pkg;

    // ******************************************************************
    // Register map
    // ******************************************************************
    localparam logic [3:0] PMC_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] PMC_ADDR_STATUS = 4'h1;
    localparam logic [3:0] PMC_ADDR_WAKE   = 4'h2;
    localparam logic [3:0] PMC_ADDR_OPCODE = 4'h3;

    // Control register fields.
    localparam int PMC_CTRL_SLOW_BIT   = 0;
    localparam int PMC_CTRL_DIV_LSB    = 1;
    localparam int PMC_CTRL_TBIE_BIT   = 3;
    localparam int PMC_CTRL_LONG_BIT   = 4;
    localparam int PMC_CTRL_WDGH_BIT   = 5;
    localparam logic [31:0] PMC_CTRL_RESET = 32'h0000_0000;

    // Wake source positions in the wake register.
    localparam int PMC_WK_SPI_SLAVE = 0;
    localparam int PMC_WK_ART_EXT   = 1;

    localparam logic [31:0] PMC_UNMAPPED_DATA = 32'h0000_0000;

    // ******************************************************************
    // Encodings and timing
    // ******************************************************************
    localparam logic [7:0] PMC_HALT_OPCODE = 8'h8E;
    localparam logic [1:0] PMC_MASK_ALL_ON = 2'b10;
    localparam int PMC_DELAY_SHORT = 256;
    localparam int PMC_DELAY_LONG  = 4096;
    localparam int PMC_MCLK_MULT   = 2;

    typedef enum logic [5:0] {
        PMC_ST_RUN     = 6'b00_0001,
        PMC_ST_WAIT    = 6'b00_0010,
        PMC_ST_AHALT   = 6'b00_0100,
        PMC_ST_HALT    = 6'b00_1000,
        PMC_ST_STAB    = 6'b01_0000,
        PMC_ST_RESUME  = 6'b10_0000
    } pmc_state_t;

    // CPU side request group.
    typedef struct packed {
        logic       wait_for_interrupt_instruction;
        logic       exec;
        logic [7:0] opcode;
    } pmc_cpu_req_t;

    // Interrupt side group.
    typedef struct packed {
        logic any_irq;
        logic ext_irq;
        logic tb_irq;
        logic spi_irq;
        logic art_irq;
    } pmc_irq_t;

endpackage : pmc_pkg

/* File: dv/pmc_cpu_model.sv */
module pmc_cpu_model (
    // Clock and resume pulse
    input  wire logic              clk_in,
    input  wire logic              wake_service_in,
    // Requests towards the controller
    output pmc_pkg::pmc_cpu_req_t  cpu_req_out,
    output pmc_pkg::pmc_irq_t      irq_out,
    output logic                   wdg_active_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import pmc_pkg::*;

    initial begin
        cpu_req_out = '0;
        irq_out = '0;
        wdg_active_out = 1'b0;
    end

    // source acknowledged
    // The core services the wakeup and acknowledges its source, so a level
    // request drops once the resume pulse is seen.
    always @(posedge clk_in) begin
        if (wake_service_in === 1'b1) begin
            irq_out <= '0;
        end
    end

    task automatic issue(input logic w, input logic [7:0] op);
        cpu_req_out.opcode <= op;
        cpu_req_out.wait_for_interrupt_instruction <= w;
        cpu_req_out.exec <= ~w;
        if (!w && op == PMC_HALT_OPCODE) begin
            irq_out <= '0;
        end
        @(posedge clk_in);
        cpu_req_out.wait_for_interrupt_instruction <= 1'b0;
        cpu_req_out.exec <= 1'b0;
    endtask : issue

    task automatic set_irq(input pmc_irq_t v);
        irq_out <= v;
    endtask : set_irq

    task automatic set_wdg(input logic v);
        wdg_active_out <= v;
    endtask : set_wdg
endmodule : pmc_cpu_model

/* File: dv/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pmc_pkg::*;

    // Short delays keep the run brief; expectations derive from these.
    localparam int DS = 8;
    localparam int DL = 16;

    logic          MCLK_IN, RST_N_IN, AVS_READ_IN, AVS_WRITE_IN;
    logic [3:0]    AVS_ADDRESS_IN;
    logic [31:0]   AVS_WRITEDATA_IN, AVS_READDATA_OUT, rdv;
    logic          AVS_WAITREQUEST_OUT, WDG_ACTIVE_IN, WAKE_SERVICE_OUT;
    logic          CPU_CLK_EN_OUT, PERIPH_CLK_EN_OUT, OSC_EN_OUT;
    logic          TIMEBASE_EN_OUT, MASK_FORCE_OUT, WDG_RESET_OUT;
    logic [1:0]    MASK_LEVEL_OUT;
    logic [4:0]    CLK_DIV_OUT;
    pmc_cpu_req_t  CPU_REQ_IN;
    pmc_irq_t      IRQ_IN;
    int            errors, tests_run, cyc, wdg_seen;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [4:0]  div;
    } pmc_row_t;
    pmc_row_t rows [6] = '{'{32'h0000_0000, 5'h01}, '{32'h0000_0006, 5'h01},
        '{32'h0000_0001, 5'h02}, '{32'h0000_0003, 5'h04},
        '{32'h0000_0005, 5'h08}, '{32'h0000_0007, 5'h10}};

    pmc_ctrl #(.DELAY_SHORT(DS), .DELAY_LONG(DL)) pmc_ctrl_i (
        .MCLK_IN(MCLK_IN),
        .RST_N_IN(RST_N_IN),
        .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
        .AVS_READ_IN(AVS_READ_IN),
        .AVS_WRITE_IN(AVS_WRITE_IN),
        .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
        .AVS_READDATA_OUT(AVS_READDATA_OUT),
        .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
        .CPU_REQ_IN(CPU_REQ_IN),
        .WDG_ACTIVE_IN(WDG_ACTIVE_IN),
        .IRQ_IN(IRQ_IN),
        .CPU_CLK_EN_OUT(CPU_CLK_EN_OUT),
        .PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT),
        .OSC_EN_OUT(OSC_EN_OUT),
        .TIMEBASE_EN_OUT(TIMEBASE_EN_OUT),
        .MASK_FORCE_OUT(MASK_FORCE_OUT),
        .MASK_LEVEL_OUT(MASK_LEVEL_OUT),
        .WAKE_SERVICE_OUT(WAKE_SERVICE_OUT),
        .WDG_RESET_OUT(WDG_RESET_OUT),
        .CLK_DIV_OUT(CLK_DIV_OUT));
    pmc_cpu_model pmc_cpu_model_i (.clk_in(MCLK_IN),
        .wake_service_in(WAKE_SERVICE_OUT), .cpu_req_out(CPU_REQ_IN),
        .irq_out(IRQ_IN), .wdg_active_out(WDG_ACTIVE_IN));

    initial begin
        MCLK_IN = 1'b0;
        forever #4 MCLK_IN = ~MCLK_IN;
    end

    always @(posedge MCLK_IN) begin
        if (WDG_RESET_OUT === 1'b1) begin
            wdg_seen++;
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic ticks(input int n);
        repeat (n) @(posedge MCLK_IN);
    endtask : ticks

    // The request stays up until waitrequest is seen low at an edge.
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        AVS_ADDRESS_IN <= a;
        AVS_WRITEDATA_IN <= d;
        AVS_WRITE_IN <= wr;
        AVS_READ_IN <= ~wr;
        do begin
            @(posedge MCLK_IN);
            n++;
        end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 50);
        rdv = AVS_READDATA_OUT;
        AVS_WRITE_IN <= 1'b0;
        AVS_READ_IN <= 1'b0;
        @(posedge MCLK_IN);
        if (n >= 50) begin
            chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
            tally_and_finish();
        end
    endtask : bus

    task automatic st(input pmc_state_t s);
        bus(1'b0, PMC_ADDR_STATUS, 32'h0000_0000);
        chk("status", 32'(s), rdv);
    endtask : st

    task automatic gates(input logic [2:0] e);
        chk("cpu_periph_osc", 32'(e),
            32'({CPU_CLK_EN_OUT, PERIPH_CLK_EN_OUT, OSC_EN_OUT}));
    endtask : gates

    task automatic wait_wake(input int lim);
        cyc = 0;
        do begin
            @(posedge MCLK_IN);
            cyc++;
        end while (WAKE_SERVICE_OUT !== 1'b1 && cyc < lim);
        chk("wake_service", 32'h0000_0001, 32'(WAKE_SERVICE_OUT));
    endtask : wait_wake

    task automatic do_reset();
        RST_N_IN <= 1'b0;
        ticks(3);
        gates(3'b001);
        chk("clk_div", 32'h0000_0001, 32'(CLK_DIV_OUT));
        RST_N_IN <= 1'b1;
        cyc = 0;
        do begin
            @(posedge MCLK_IN);
            cyc++;
        end while (CPU_CLK_EN_OUT !== 1'b1 && cyc < DL + 40);
        chk("reset_delay", 32'h0000_0001,
            32'(cyc >= DS && cyc < DL + 40));
        st(PMC_ST_RUN);
    endtask : do_reset

    initial begin
        errors = 0;
        tests_run = 0;
        wdg_seen = 0;
        RST_N_IN = 1'b0;
        AVS_READ_IN = 1'b0;
        AVS_WRITE_IN = 1'b0;
        AVS_ADDRESS_IN = 4'h0;
        AVS_WRITEDATA_IN = 32'h0000_0000;
        do_reset();
        bus(1'b1, 4'hF, 32'hFFFF_FFFF);
        bus(1'b0, 4'hF, 32'h0000_0000);
        chk("unmapped", PMC_UNMAPPED_DATA, rdv);
        bus(1'b0, PMC_ADDR_CTRL, 32'h0000_0000);
        chk("ctrl_reset", PMC_CTRL_RESET, rdv);
        $display("test reset done");
        foreach (rows[i]) begin
            bus(1'b1, PMC_ADDR_CTRL, rows[i].ctrl);
            ticks(2);
            chk("clk_div", 32'(rows[i].div), 32'(CLK_DIV_OUT));
        end
        $display("test divider table done");
        pmc_cpu_model_i.issue(1'b0, 8'h8D);
        ticks(2);
        st(PMC_ST_RUN);
        bus(1'b0, PMC_ADDR_OPCODE, 32'h0000_0000);
        chk("opcode", 32'h0000_008D, rdv);
        bus(1'b1, PMC_ADDR_CTRL, 32'h0000_0003);
        pmc_cpu_model_i.issue(1'b1, 8'h00);
        ticks(2);
        gates(3'b011);
        chk("clk_div", 32'h0000_0004, 32'(CLK_DIV_OUT));
        chk("mask", 32'h0000_0006, 32'({MASK_FORCE_OUT, MASK_LEVEL_OUT}));
        st(PMC_ST_WAIT);
        pmc_cpu_model_i.set_irq(5'h10);
        wait_wake(20);
        ticks(2);
        st(PMC_ST_RUN);
        chk("clk_div", 32'h0000_0004, 32'(CLK_DIV_OUT));
        $display("test slow wait done");
        bus(1'b1, PMC_ADDR_CTRL, 32'h0000_0008);
        pmc_cpu_model_i.set_wdg(1'b1);
        pmc_cpu_model_i.issue(1'b0, PMC_HALT_OPCODE);
        ticks(2);
        gates(3'b001);
        chk("timebase_en", 32'h0000_0001, 32'(TIMEBASE_EN_OUT));
        chk("mask", 32'h0000_0006, 32'({MASK_FORCE_OUT, MASK_LEVEL_OUT}));
        st(PMC_ST_AHALT);
        pmc_cpu_model_i.set_irq(5'h08);
        ticks(4);
        st(PMC_ST_AHALT);
        chk("wdg_reset", 32'h0000_0000, 32'(wdg_seen));
        pmc_cpu_model_i.set_irq(5'h04);
        wait_wake(DS);
        bus(1'b1, PMC_ADDR_CTRL, 32'h0000_0000);
        ticks(2);
        st(PMC_ST_HALT);
        do_reset();
        $display("test active halt done");
        bus(1'b1, PMC_ADDR_CTRL, 32'h0000_0020);
        pmc_cpu_model_i.issue(1'b0, PMC_HALT_OPCODE);
        ticks(2);
        gates(3'b000);
        pmc_cpu_model_i.set_irq(5'h07);
        ticks(4);
        st(PMC_ST_HALT);
        chk("wdg_reset", 32'h0000_0000, 32'(wdg_seen));
        bus(1'b1, PMC_ADDR_WAKE, 32'h0000_0001);
        wait_wake(DS + 30);
        chk("short_delay", 32'h0000_0001, 32'(cyc >= DS));
        bus(1'b1, PMC_ADDR_WAKE, 32'h0000_0002);
        pmc_cpu_model_i.issue(1'b0, PMC_HALT_OPCODE);
        ticks(2);
        pmc_cpu_model_i.set_irq(5'h02);
        ticks(4);
        st(PMC_ST_HALT);
        pmc_cpu_model_i.set_irq(5'h01);
        wait_wake(DS + 30);
        chk("art_delay", 32'h0000_0001, 32'(cyc >= DS));
        bus(1'b1, PMC_ADDR_CTRL, 32'h0000_0030);
        pmc_cpu_model_i.issue(1'b0, PMC_HALT_OPCODE);
        ticks(2);
        pmc_cpu_model_i.set_irq(5'h08);
        wait_wake(DL + 30);
        chk("long_delay", 32'h0000_0001, 32'(cyc >= DL));
        $display("test halt done");
        bus(1'b1, PMC_ADDR_CTRL, 32'h0000_0000);
        pmc_cpu_model_i.issue(1'b0, PMC_HALT_OPCODE);
        ticks(4);
        chk("wdg_reset", 32'h0000_0001, 32'(wdg_seen));
        pmc_cpu_model_i.set_wdg(1'b0);
        do_reset();
        $display("test watchdog done");
        tally_and_finish();
    end
endmodule : testbench
